// file: core/uxb_regs.svh
`ifndef UXB_REGS_SVH
`define UXB_REGS_SVH

// ==========================================================
// register map (byte addresses on the register bus)
`define UXB_ADDR_CONFIG 12'h000
`define UXB_ADDR_DATA 12'h004
`define UXB_ADDR_STATUS 12'h008

// ==========================================================
// configuration register fields
`define UXB_CFG_WORD7 0
`define UXB_CFG_EXTRA_EN 1
`define UXB_CFG_EXTRA_MASK 2
`define UXB_CFG_READY_MASK 3
`define UXB_CFG_ACT_MASK 4
`define UXB_CFG_RTS 5
`define UXB_CFG_RESET 6'h00

// ==========================================================
// data register fields
`define UXB_DATA_EXTRA 8
`define UXB_DATA_PENDING 9

// ==========================================================
// status register fields
`define UXB_STAT_PENDING 0
`define UXB_STAT_TX_EMPTY 1
`define UXB_STAT_ACT_FLAG 2
`define UXB_STAT_EXTRA 3

// ==========================================================
// link timing, in link clock cycles
`define UXB_BIT_CYCLES 8'h10
`define UXB_HALF_BIT 8'h08

`endif

// file: core/uxb_pkg.sv
package uxb_pkg;

  // ==========================================================
  // receiver sequencing
  typedef enum logic [1:0] {rx_idle, rx_start, rx_data, rx_stop} uxb_rx_state_type;

  // fifo entry: extra bit on top of the data byte
  typedef logic [8:0] uxb_entry_type;

endpackage

// file: core/uxb_link.sv
`timescale 1ns/1ps
`include "uxb_regs.svh"

module uxb_link (
  input wire logic link_clk_in,
  input wire logic rst_in,
  input wire logic rx_line_in,
  input wire logic word7_in,
  input wire logic extra_en_in,
  input wire logic tx_req_tgl_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_extra_in,
  output logic tx_line_out,
  output logic tx_ack_tgl_out,
  output logic rx_tgl_out,
  output logic [7:0] rx_data_out,
  output logic rx_extra_out,
  output logic framing_out
);

  // ==========================================================
  // synchronisers: line, config levels, request toggle
  // reset values match what the other domain shows in reset (line idle
  // high, config zero, toggle low) so no false request follows reset
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  always_ff @(posedge link_clk_in or posedge rst_in)
    if (rst_in)
      begin
        sync_a <= 4'h1;
        sync_b <= 4'h1;
      end
    else
      begin
        sync_a <= {tx_req_tgl_in, extra_en_in, word7_in, rx_line_in};
        sync_b <= sync_a;
      end

  logic rx_s, w7, pe, req_s;
  assign {req_s, pe, w7, rx_s} = sync_b;
  logic [3:0] nbits;
  assign nbits = 4'h8 - {3'h0, w7} + {3'h0, pe};

  // ==========================================================
  // transmitter: start, payload, extra bit when enabled, stop
  logic [10:0] tx_shift;
  logic [3:0] tx_left;
  logic [7:0] tx_cnt;
  logic req_seen;
  logic [8:0] pay;
  always_comb
  begin
    pay = 9'h1ff;
    pay[6:0] = tx_data_in[6:0];
    if (!w7)
      pay[7] = tx_data_in[7];
    if (pe && w7)
      pay[7] = tx_extra_in;
    if (pe && !w7)
      pay[8] = tx_extra_in;
  end

  always_ff @(posedge link_clk_in or posedge rst_in)
    if (rst_in)
      begin
        tx_shift <= 11'h7ff;
        tx_left <= 4'h0;
        tx_cnt <= 8'h00;
        req_seen <= 1'b0;
        tx_ack_tgl_out <= 1'b0;
      end
    else if (tx_left == 4'h0)
      begin
        if (req_s != req_seen)
          begin
            tx_shift <= {1'b1, pay, 1'b0}; // ones past the payload are stop level
            tx_left <= nbits + 4'h2;
            tx_cnt <= `UXB_BIT_CYCLES;
            req_seen <= req_s;
          end
      end
    else if (tx_cnt == 8'h01)
      begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_left <= tx_left - 4'h1;
        tx_cnt <= `UXB_BIT_CYCLES;
        if (tx_left == 4'h1)
          tx_ack_tgl_out <= ~tx_ack_tgl_out;
      end
    else
      tx_cnt <= tx_cnt - 8'h01;

  assign tx_line_out = tx_shift[0];

  // ==========================================================
  // receiver: waits for a falling edge, samples mid-bit
  uxb_pkg::uxb_rx_state_type rx_state;
  logic [7:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [8:0] rx_buf;
  logic rx_prev;
  always_ff @(posedge link_clk_in or posedge rst_in)
    if (rst_in)
      begin
        rx_state <= uxb_pkg::rx_idle;
        rx_cnt <= 8'h00;
        rx_idx <= 4'h0;
        rx_buf <= 9'h000;
        rx_prev <= 1'b1;
        rx_tgl_out <= 1'b0;
        rx_data_out <= 8'h00;
        rx_extra_out <= 1'b0;
        framing_out <= 1'b0;
      end
    else
      begin
        rx_prev <= rx_s;
        unique case (rx_state)
          uxb_pkg::rx_idle:
            if (rx_prev && !rx_s)
              begin
                rx_state <= uxb_pkg::rx_start;
                rx_cnt <= `UXB_HALF_BIT;
                rx_buf <= 9'h000;
                rx_idx <= 4'h0;
              end
          uxb_pkg::rx_start:
            if (rx_cnt != 8'h01)
              rx_cnt <= rx_cnt - 8'h01;
            else if (rx_s)
              rx_state <= uxb_pkg::rx_idle; // glitch, not a start bit
            else
              begin
                rx_state <= uxb_pkg::rx_data;
                rx_cnt <= `UXB_BIT_CYCLES;
              end
          uxb_pkg::rx_data:
            if (rx_cnt != 8'h01)
              rx_cnt <= rx_cnt - 8'h01;
            else
              begin
                rx_buf[rx_idx] <= rx_s; // extra bit lands after the data bits
                rx_idx <= rx_idx + 4'h1;
                rx_cnt <= `UXB_BIT_CYCLES;
                if (rx_idx == nbits - 4'h1)
                  rx_state <= uxb_pkg::rx_stop;
              end
          uxb_pkg::rx_stop:
            if (rx_cnt != 8'h01)
              rx_cnt <= rx_cnt - 8'h01;
            else
              begin
                rx_state <= uxb_pkg::rx_idle;
                framing_out <= ~rx_s;
                if (rx_s)
                  begin
                    rx_data_out <= {rx_buf[7] & ~w7, rx_buf[6:0]};
                    rx_extra_out <= pe & (w7 ? rx_buf[7] : rx_buf[8]);
                    rx_tgl_out <= ~rx_tgl_out;
                  end
              end
        endcase
      end

endmodule

// file: core/uxb_top.sv
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "uxb_regs.svh"

module uxb_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic link_clk_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_line_in,
  output logic tx_line_out,
  output logic irq_n_out,
  output logic rts_n_out
);

  // ==========================================================
  // bus phases
  logic setup;
  logic access;
  logic hit_config;
  logic hit_data;
  logic hit_status;
  logic bad_addr;

  // zero wait states: every access completes in its first access cycle
  assign pready_out = psel_in & penable_in;
  assign setup = psel_in & ~penable_in;
  assign access = psel_in & penable_in;

  // address decode, full word address compared
  assign hit_config = (paddr_in == `UXB_ADDR_CONFIG);
  assign hit_data = (paddr_in == `UXB_ADDR_DATA);
  assign hit_status = (paddr_in == `UXB_ADDR_STATUS);
  assign bad_addr = ~(hit_config | hit_data | hit_status);

  // unmapped addresses answer with an error on the access cycle
  assign pslverr_out = access & bad_addr;

  // ==========================================================
  // configuration register
  logic [5:0] cfg;
  logic word7;
  logic extra_en;
  logic extra_mask;
  logic ready_mask;
  logic act_mask;
  logic rts;

  // one register keeps all mode and mask bits together
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      cfg <= `UXB_CFG_RESET;
    else if (access && pwrite_in && hit_config)
      cfg <= pwdata_in[5:0];

  assign word7 = cfg[`UXB_CFG_WORD7];
  assign extra_en = cfg[`UXB_CFG_EXTRA_EN];
  assign extra_mask = cfg[`UXB_CFG_EXTRA_MASK];
  assign ready_mask = cfg[`UXB_CFG_READY_MASK];
  assign act_mask = cfg[`UXB_CFG_ACT_MASK];
  assign rts = cfg[`UXB_CFG_RTS];

  // ==========================================================
  // crossing from the link domain
  // rx toggle, tx ack toggle and framing level each pass two flops;
  // the received word itself is held steady by the link for a whole
  // character time, so it is sampled only after its toggle arrives
  logic link_rx_tgl;
  logic link_ack_tgl;
  logic link_fe;
  logic [7:0] link_rx_data;
  logic link_rx_extra;
  logic [2:0] xs_a;
  logic [2:0] xs_b;

  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      begin
        xs_a <= 3'h0;
        xs_b <= 3'h0;
      end
    else
      begin
        xs_a <= {link_fe, link_ack_tgl, link_rx_tgl};
        xs_b <= xs_a;
      end

  logic rx_seen;
  logic ack_seen;
  logic rx_event;
  logic ack_event;
  logic fe_flag;

  assign rx_event = xs_b[0] ^ rx_seen;
  assign ack_event = xs_b[1] ^ ack_seen;
  assign fe_flag = xs_b[2];

  // remember which toggle levels have already been consumed
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      begin
        rx_seen <= 1'b0;
        ack_seen <= 1'b0;
      end
    else
      begin
        rx_seen <= xs_b[0];
        ack_seen <= xs_b[1];
      end

  // ==========================================================
  // receive fifo, eight words of data plus extra bit
  uxb_pkg::uxb_entry_type fifo_mem [0:7];
  logic [2:0] wr_ptr;
  logic [2:0] rd_ptr;
  logic [3:0] fifo_count;
  logic push;
  logic pop;
  logic pending;
  uxb_pkg::uxb_entry_type head;

  // a word arriving into a full fifo is dropped; the oldest are kept
  assign push = rx_event & (fifo_count != 4'h8);

  // the word leaves at the edge that completes the data read, so the
  // pending flag stays high for the whole read that returns it
  assign pop = access & ~pwrite_in & hit_data & pending;
  assign pending = (fifo_count != 4'h0);
  assign head = fifo_mem[rd_ptr];

  // storage writes
  always_ff @(posedge clk_in)
    if (push)
      fifo_mem[wr_ptr] <= {link_rx_extra, link_rx_data};

  // pointers and occupancy
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      begin
        wr_ptr <= 3'h0;
        rd_ptr <= 3'h0;
        fifo_count <= 4'h0;
      end
    else
      begin
        if (push)
          wr_ptr <= wr_ptr + 3'h1;
        if (pop)
          rd_ptr <= rd_ptr + 3'h1;
        // a push in the same cycle as the last pop keeps the flag set
        if (push && !pop)
          fifo_count <= fifo_count + 4'h1;
        else if (pop && !push)
          fifo_count <= fifo_count - 4'h1;
      end

  logic rx_extra_bit;
  // an empty fifo reports no extra bit
  assign rx_extra_bit = pending & head[8];

  // ==========================================================
  // transmit holding register
  logic [7:0] tx_data;
  logic tx_extra_bit;
  logic tx_req_tgl;
  logic tx_busy;

  // a data write while a character is still in flight is ignored
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      begin
        tx_data <= 8'h00;
        tx_extra_bit <= 1'b0;
        tx_req_tgl <= 1'b0;
        tx_busy <= 1'b0;
      end
    else if (access && pwrite_in && hit_data && !tx_busy)
      begin
        tx_data <= pwdata_in[7:0];
        tx_extra_bit <= pwdata_in[`UXB_DATA_EXTRA];
        tx_req_tgl <= ~tx_req_tgl;
        tx_busy <= 1'b1;
      end
    else if (ack_event)
      tx_busy <= 1'b0;

  // ==========================================================
  // read data, captured in the setup cycle
  // capturing early keeps prdata a flop output and lets the pop
  // happen at the end of the access without disturbing the answer
  logic [31:0] next_prdata;

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit_config)
      next_prdata[5:0] = cfg;
    else if (hit_data)
      begin
        next_prdata[7:0] = pending ? head[7:0] : 8'h00;
        next_prdata[`UXB_DATA_EXTRA] = rx_extra_bit;
        next_prdata[`UXB_DATA_PENDING] = pending;
      end
    else if (hit_status)
      begin
        next_prdata[`UXB_STAT_PENDING] = pending;
        next_prdata[`UXB_STAT_TX_EMPTY] = ~tx_busy;
        next_prdata[`UXB_STAT_ACT_FLAG] = fe_flag;
        next_prdata[`UXB_STAT_EXTRA] = rx_extra_bit;
      end
  end

  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      prdata_out <= 32'h0000_0000;
    else if (setup && !pwrite_in)
      prdata_out <= next_prdata;

  // ==========================================================
  // interrupt and handshake pins
  logic next_irq_n;

  // level output: it falls while any enabled source holds and rises
  // one cycle after the last one goes away
  assign next_irq_n = ~((extra_mask & rx_extra_bit)
                      | (ready_mask & pending)
                      | (act_mask & fe_flag));

  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      irq_n_out <= 1'b1;
    else
      irq_n_out <= next_irq_n;

  // request-to-send pin is low-true, so the bit is inverted
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      rts_n_out <= 1'b1;
    else
      rts_n_out <= ~rts;

  // ==========================================================
  // serial line logic on the link clock
  // word length and enable are quasi-static levels; software should
  // change them only while the line is idle
  uxb_link link_unit (
    .link_clk_in(link_clk_in),
    .rst_in(rst_in),
    .rx_line_in(rx_line_in),
    .word7_in(word7),
    .extra_en_in(extra_en),
    .tx_req_tgl_in(tx_req_tgl),
    .tx_data_in(tx_data),
    .tx_extra_in(tx_extra_bit),
    .tx_line_out(tx_line_out),
    .tx_ack_tgl_out(link_ack_tgl),
    .rx_tgl_out(link_rx_tgl),
    .rx_data_out(link_rx_data),
    .rx_extra_out(link_rx_extra),
    .framing_out(link_fe)
  );

endmodule

// file: tb/uxb_monitor.sv
`timescale 1ns/1ps
`include "uxb_regs.svh"

// ==========================================================
// port-level checker for the register bus and the pins
module uxb_monitor (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  input wire logic irq_n_out,
  input wire logic rts_n_out
);
  logic [5:0] shadow;
  logic acc;
  logic rd_cfg;
  logic rd_stat;
  logic rd_data;
  logic wr_cfg;

  // decoded access cycles
  assign acc = psel_in && penable_in;
  assign wr_cfg = acc && pwrite_in && paddr_in == `UXB_ADDR_CONFIG;
  assign rd_cfg = acc && !pwrite_in && paddr_in == `UXB_ADDR_CONFIG;
  assign rd_stat = acc && !pwrite_in && paddr_in == `UXB_ADDR_STATUS;
  assign rd_data = acc && !pwrite_in && paddr_in == `UXB_ADDR_DATA;

  // last written config; masks seen here stand in for the hidden register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      shadow <= 6'h00;
    else if (wr_cfg)
      shadow <= pwdata_in[5:0];
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // ==========================================================
  // assertions
  // read data and the interrupt pin are both loaded at the setup edge, so
  // in the access cycle they describe the same moment
  a_unmapped_error: assert property (acc && paddr_in != `UXB_ADDR_CONFIG && paddr_in != `UXB_ADDR_DATA
    && paddr_in != `UXB_ADDR_STATUS |-> pslverr_out && (pwrite_in || prdata_out == 32'h0))
    else $error("unmapped access");
  a_cfg_readback: assert property (rd_cfg |-> prdata_out == {26'h0, shadow}) else $error("cfg readback");
  a_rts_tracks_bit: assert property (wr_cfg |=> ##1 rts_n_out == !$past(shadow[5])) else $error("rts level");
  a_reset_levels: assert property ($fell(rst_in) |-> rts_n_out && irq_n_out) else $error("reset levels");
  a_irq_quiet_masks: assert property (rd_cfg && prdata_out[4:2] == 3'h0 |-> irq_n_out) else $error("irq unmasked");
  a_empty_read_zero: assert property (rd_data && !prdata_out[9] |-> prdata_out == 32'h0) else $error("empty read");
  a_irq_extra_src: assert property (rd_stat && shadow[2] && prdata_out[3] |-> !irq_n_out) else $error("irq extra");
  a_irq_ready_src: assert property (rd_stat && shadow[3] && prdata_out[0] |-> !irq_n_out) else $error("irq ready");
  a_irq_frame_src: assert property (rd_stat && shadow[4] && prdata_out[2] |-> !irq_n_out) else $error("irq frame");

  // main scenarios reached
  c_cfg_write: cover property (wr_cfg);
  c_pop_read: cover property (rd_data && prdata_out[9]);
  c_irq_low: cover property ($fell(irq_n_out));
endmodule

bind uxb_top uxb_monitor i_mon (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pslverr_out(pslverr_out), .irq_n_out(irq_n_out), .rts_n_out(rts_n_out));

// file: tb/uxb_peer.sv
`timescale 1ns/1ps

// ==========================================================
// serial far end: sends frames and captures the design's frames
module uxb_peer (
  input wire logic link_clk_in,
  input wire logic rst_in,
  input wire logic tx_line_in,
  output logic rx_line_out
);
  int nbits = 8;
  int k;
  logic [9:0] w;
  logic [9:0] got[$];

  initial rx_line_out = 1'b1;

  // start bit then n bits lsb first; line idles high afterwards
  task automatic send(input logic [9:0] f, input int n);
    int i;
    @(posedge link_clk_in);
    rx_line_out <= 1'b0;
    repeat (16) @(posedge link_clk_in);
    for (i = 0; i < n; i++)
    begin
      rx_line_out <= f[i];
      repeat (16) @(posedge link_clk_in);
    end
    rx_line_out <= 1'b1;
    repeat (16) @(posedge link_clk_in);
  endtask

  // mid-bit capture; the stop bit lands on top of the word
  initial
  begin
    forever
    begin
      @(negedge tx_line_in);
      if (!rst_in)
      begin
        repeat (8) @(posedge link_clk_in);
        w = 10'h000;
        for (k = 0; k <= nbits; k++)
        begin
          repeat (16) @(posedge link_clk_in);
          w[k] = tx_line_in;
        end
        got.push_back(w);
      end
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
`include "uxb_regs.svh"

module testbench;
  logic clk_in, link_clk_in, rst_in, psel_in, penable_in, pwrite_in, rx_line_in, rerr;
  logic pready_out, pslverr_out, tx_line_out, irq_n_out, rts_n_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rdata, r;
  logic [8:0] w[3];
  int n_mismatch = 0;
  int comparisons = 0;
  int k;

  uxb_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .rx_line_in(rx_line_in),
    .tx_line_out(tx_line_out), .irq_n_out(irq_n_out), .rts_n_out(rts_n_out));
  uxb_peer i_peer (.link_clk_in(link_clk_in), .rst_in(rst_in), .tx_line_in(tx_line_out), .rx_line_out(rx_line_in));

  // ==========================================================
  // clocks; the link clock is offset so the domains never line up
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial
  begin
    link_clk_in = 1'b0;
    #3;
    forever #6 link_clk_in = ~link_clk_in;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one transfer; an idle cycle after it keeps drivers single per step
  // the wait has no limit of its own; the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1)
      @(posedge clk_in);
    rdata = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_in);
  endtask

  // frame bits after the start bit, lsb first, stop on top
  function automatic logic [9:0] frm(input logic [7:0] d, input logic x, input logic en, input logic w7,
    input logic stop);
    int n;
    n = w7 ? 7 : 8;
    frm = 10'(d) & ((10'h001 << n) - 10'h001);
    if (en)
      frm[n] = x;
    frm[n + int'(en)] = stop;
  endfunction

  task automatic rx_send(input logic [9:0] f, input int n);
    i_peer.send(f, n);
    repeat (9) @(posedge clk_in);
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 3000 && i_peer.got.size() == 0; i++)
      @(posedge clk_in);
    apb(1'b0, `UXB_ADDR_STATUS, 32'h0);
    for (i = 0; i < 100 && rdata[1] !== 1'b1; i++)
      apb(1'b0, `UXB_ADDR_STATUS, 32'h0);
  endtask

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk_in);
    check("irq_n", irq_n_out, exp);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    rst_in = 1'b1;
    k = $urandom(42);
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    check("rts_n", rts_n_out, 1);
    apb(1'b0, `UXB_ADDR_CONFIG, 32'h0);
    check("cfg", rdata, 0);
    apb(1'b0, `UXB_ADDR_STATUS, 32'h0);
    check("status", rdata, 32'h2);
    apb(1'b0, 12'h00c, 32'h0);
    check("slverr", rerr, 1);
    // random config with junk upper bits
    repeat (4)
    begin
      r = $urandom;
      apb(1'b1, `UXB_ADDR_CONFIG, r);
      apb(1'b0, `UXB_ADDR_CONFIG, 32'h0);
      check("cfg", rdata, r & 32'h3f);
      check("rts_n", rts_n_out, !r[5]);
    end
    // every word length with extra bit on and off; extra set while off
    for (k = 0; k < 4; k++)
    begin
      i_peer.nbits = (k[1] ? 7 : 8) + k[0];
      apb(1'b1, `UXB_ADDR_CONFIG, {30'h0, k[0], k[1]});
      r = $urandom;
      if (!k[0])
        r[8] = 1'b1;
      apb(1'b1, `UXB_ADDR_DATA, r);
      wait_idle();
      check("tx_frame", i_peer.got.pop_front(), frm(r[7:0], r[8], k[0], k[1], 1'b1));
    end
    // three received words, each with its own extra bit
    apb(1'b1, `UXB_ADDR_CONFIG, 32'h2);
    for (k = 0; k < 3; k++)
      w[k] = 9'($urandom);
    w[0][8] = 1'b1;
    w[1][8] = 1'b0;
    for (k = 0; k < 3; k++)
      rx_send(frm(w[k][7:0], w[k][8], 1'b1, 1'b0, 1'b1), 10);
    irq_is(1'b1);
    apb(1'b0, `UXB_ADDR_STATUS, 32'h0);
    check("status", rdata, 32'hb);
    apb(1'b1, `UXB_ADDR_CONFIG, 32'h6);
    irq_is(1'b0);
    apb(1'b1, `UXB_ADDR_CONFIG, 32'ha);
    irq_is(1'b0);
    for (k = 0; k < 3; k++)
    begin
      apb(1'b0, `UXB_ADDR_DATA, 32'h0);
      check("rx_word", rdata, {22'h0, 1'b1, w[k]});
    end
    irq_is(1'b1);
    apb(1'b0, `UXB_ADDR_STATUS, 32'h0);
    check("status", rdata, 32'h2);
    apb(1'b0, `UXB_ADDR_DATA, 32'h0);
    check("rx_empty", rdata, 0);
    // framing error raises the flag, a good word clears it
    apb(1'b1, `UXB_ADDR_CONFIG, 32'h12);
    rx_send(frm(8'h5a, 1'b0, 1'b1, 1'b0, 1'b0), 10);
    apb(1'b0, `UXB_ADDR_STATUS, 32'h0);
    check("status", rdata, 32'h6);
    irq_is(1'b0);
    rx_send(frm(8'ha5, 1'b1, 1'b1, 1'b0, 1'b1), 10);
    apb(1'b0, `UXB_ADDR_STATUS, 32'h0);
    check("status", rdata, 32'hb);
    irq_is(1'b1);
    apb(1'b0, `UXB_ADDR_DATA, 32'h0);
    check("rx_word", rdata, 32'h3a5);
    // seven-bit words, extra bit off: stop must not read as extra
    apb(1'b1, `UXB_ADDR_CONFIG, 32'h1);
    rx_send(frm(8'hff, 1'b0, 1'b0, 1'b1, 1'b1), 8);
    apb(1'b0, `UXB_ADDR_DATA, 32'h0);
    check("rx_word", rdata, 32'h27f);
    tally_and_finish();
  end

  // hang guard, well past the expected run of about 25 us
  initial
  begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
